// *** verilog/fpir_pkg.sv ***
/*
 * Constants for the fiber next-page and interrupt register bank:
 * register offsets, field positions, widths and values after reset.
 * Assumes a 12-bit register address and 16-bit register data.
 */
package fpir_pkg;

  // ----------------------------------------------------------------
  // Register bus geometry
  // ----------------------------------------------------------------
  localparam int FPIR_AW = 12;
  localparam int FPIR_DW = 16;
  localparam int FPIR_NIRQ = 10;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [FPIR_AW-1:0] FPIR_OFS_PARTNER_NEXT_PAGE = 12'hC08;
  localparam logic [FPIR_AW-1:0] FPIR_OFS_FIBER_CONFIG_0 = 12'hC10;
  localparam logic [FPIR_AW-1:0] FPIR_OFS_FIBER_IRQ_ENABLE = 12'hC18;
  localparam logic [FPIR_AW-1:0] FPIR_OFS_FIBER_IRQ_STATUS = 12'hC19;
  localparam logic [FPIR_AW-1:0] FPIR_OFS_FIBER_TEST_CONTROL = 12'hC1A;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [FPIR_DW-1:0] FPIR_RST_PARTNER_NEXT_PAGE = 16'h0000;
  localparam logic [FPIR_NIRQ-1:0] FPIR_RST_IRQ_ENABLE = 10'h3FF;
  localparam logic [FPIR_NIRQ-1:0] FPIR_RST_IRQ_STATUS = 10'h000;

  // ----------------------------------------------------------------
  // Partner next page fields
  // ----------------------------------------------------------------
  localparam int FPIR_NP_MORE_PAGES = 15;
  localparam int FPIR_NP_ACKNOWLEDGE = 14;
  localparam int FPIR_NP_PAGE_TYPE = 13;
  localparam int FPIR_NP_CAN_COMPLY = 12;
  localparam int FPIR_NP_TOGGLE = 11;
  localparam int FPIR_NP_CODE_MSB = 10;

  // ----------------------------------------------------------------
  // Configuration and test control fields
  // ----------------------------------------------------------------
  localparam int FPIR_CFG_USE_SD_PIN = 9;
  localparam int FPIR_TST_REV_LOOPBACK = 5;

  // ----------------------------------------------------------------
  // Interrupt source positions (enable and status alike)
  // ----------------------------------------------------------------
  localparam int FPIR_IRQ_FAR_END_FAULT = 9;
  localparam int FPIR_IRQ_TX_FIFO_FULL = 8;
  localparam int FPIR_IRQ_TX_FIFO_EMPTY = 7;
  localparam int FPIR_IRQ_RX_FIFO_FULL = 6;
  localparam int FPIR_IRQ_RX_FIFO_EMPTY = 5;
  localparam int FPIR_IRQ_LINK_CHANGE = 4;
  localparam int FPIR_IRQ_REMOTE_FAULT = 3;
  localparam int FPIR_IRQ_PRIORITY_FAIL = 2;
  localparam int FPIR_IRQ_NEXT_PAGE_RX = 1;
  localparam int FPIR_IRQ_BASE_PAGE_RX = 0;

endpackage : fpir_pkg

// *** verilog/fpir_flag_if.sv ***
/*
 * Interface carrying set, clear and flag vectors between the register
 * bank and its sticky flag store. Assumes one clock for both ends.
 */
`timescale 1ns/1ps

interface fpir_flag_if #(
  parameter int N = 10
);
  logic [N-1:0] set;
  logic clr;
  logic [N-1:0] flags;

  modport bank (output set, output clr, input flags);
  modport store (input set, input clr, output flags);
endinterface : fpir_flag_if

// *** verilog/fpir_sticky.sv ***
/*
 * Bank of sticky pending flags: each bit sets on its event and a clear
 * pulse clears every bit whose event is not present in the same cycle.
 * Assumes set and clear are synchronous to clk_sys.
 */
`timescale 1ns/1ps

module fpir_sticky #(
  parameter int N = 10
) (
  input wire logic clk_sys, // System clock
  input wire logic nrst, // Asynchronous reset, active low
  fpir_flag_if.store fl // Set, clear and flag vectors
);
  import fpir_pkg::*;

  logic [N-1:0] flag_q;
  logic [N-1:0] flag_d;

  // ----------------------------------------------------------------
  // Next value
  // ----------------------------------------------------------------
  // Set beats clear so an event during the clearing read survives
  always_comb begin
    flag_d = (fl.clr ? '0 : flag_q) | fl.set; // [R17]
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      flag_q <= FPIR_RST_IRQ_STATUS[N-1:0];
    end else begin
      flag_q <= flag_d; // [R17]
    end
  end

  assign fl.flags = flag_q;

endmodule : fpir_sticky

// *** verilog/fpir_regs.sv ***
/*
 * Fiber-side register bank: partner next page snapshot, signal detect
 * pin selection, ten-source interrupt enable/status and reverse loopback.
 * Assumes the negotiation engine and FIFOs drive their inputs on clk_sys;
 * only the signal detect pin comes from outside and is synchronised.
 */
// Local design decision: strobed register access.
// Operation
// [R01] Partner next page read-only; bit15 more pages
// [R02] Bit13 gives partner page type
// [R03] Bit12 gives partner can-comply flag
// [R04] Bit11 carries partner toggle value
// [R05] Bits10-0 hold partner message code
// [R06] Config bit9 selects signal detect pin
// [R07] Ten enables read/write, all set after reset
// [R08] Bit9 is far-end fault received
// [R09] Bits8,7 are transmit FIFO full, empty
// [R10] Bits6,5 are receive FIFO full, empty
// [R11] Bit4 is fiber link status change
// [R12] Bit3 is partner remote fault received
// [R13] Bit2 is priority resolution failure
// [R14] Bits1,0 are next, base page received
// [R15] Status pending reads one; read clears
// [R16] Test control bit5 enables reverse loopback
// [R17] Event during clearing read stays pending
// [R18] Interrupt while any enabled status pending
`timescale 1ns/1ps

module fpir_regs (
  input wire logic clk_sys, // System clock, 40 MHz
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic [fpir_pkg::FPIR_AW-1:0] reg_addr, // Register address
  input wire logic [fpir_pkg::FPIR_DW-1:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [fpir_pkg::FPIR_DW-1:0] reg_rdata, // Read data, cycle after strobe
  input wire logic np_rx_valid, // Partner next page received pulse
  input wire logic [fpir_pkg::FPIR_DW-1:0] np_rx_word, // Received next page word
  input wire logic bp_rx_valid, // Partner base page received pulse
  input wire logic far_end_fault, // Far-end fault indication pulse
  input wire logic tx_fifo_full, // Transmit FIFO full level
  input wire logic tx_fifo_empty, // Transmit FIFO empty level
  input wire logic rx_fifo_full, // Receive FIFO full level
  input wire logic rx_fifo_empty, // Receive FIFO empty level
  input wire logic link_up, // Fiber link status level
  input wire logic remote_fault_rx, // Partner remote fault pulse
  input wire logic priority_fail, // Priority resolution failure pulse
  input wire logic sd_pin, // Signal detect pin, asynchronous
  output logic signal_detect, // Effective signal detect
  output logic rev_loopback_en, // Fiber reverse loopback enable
  output logic irq // Interrupt, active high level
);
  import fpir_pkg::*;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic sel_np;
  logic sel_cfg;
  logic sel_en;
  logic sel_sts;
  logic sel_tst;

  assign sel_np = (reg_addr == FPIR_OFS_PARTNER_NEXT_PAGE);
  assign sel_cfg = (reg_addr == FPIR_OFS_FIBER_CONFIG_0);
  assign sel_en = (reg_addr == FPIR_OFS_FIBER_IRQ_ENABLE);
  assign sel_sts = (reg_addr == FPIR_OFS_FIBER_IRQ_STATUS);
  assign sel_tst = (reg_addr == FPIR_OFS_FIBER_TEST_CONTROL);

  // ----------------------------------------------------------------
  // Partner next page snapshot
  // ----------------------------------------------------------------
  logic [FPIR_DW-1:0] np_page_q;

  // Whole word kept as received; software sees it read-only
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      np_page_q <= FPIR_RST_PARTNER_NEXT_PAGE;
    end else if (np_rx_valid) begin
      np_page_q <= np_rx_word; // [R01] [R02] [R03] [R04] [R05]
    end
  end

  logic partner_more_pages;
  logic partner_page_acknowledge;
  logic partner_page_type;
  logic partner_can_comply;
  logic partner_toggle_bit;
  logic [FPIR_NP_CODE_MSB:0] partner_message_code;

  assign partner_more_pages = np_page_q[FPIR_NP_MORE_PAGES];
  assign partner_page_acknowledge = np_page_q[FPIR_NP_ACKNOWLEDGE];
  assign partner_page_type = np_page_q[FPIR_NP_PAGE_TYPE];
  assign partner_can_comply = np_page_q[FPIR_NP_CAN_COMPLY];
  assign partner_toggle_bit = np_page_q[FPIR_NP_TOGGLE];
  assign partner_message_code = np_page_q[FPIR_NP_CODE_MSB:0];

  // ----------------------------------------------------------------
  // Configuration: signal detect pin selection
  // ----------------------------------------------------------------
  logic use_signal_detect_pin_q;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      use_signal_detect_pin_q <= 1'b0;
    end else if (reg_wr && sel_cfg) begin
      use_signal_detect_pin_q <= reg_wdata[FPIR_CFG_USE_SD_PIN]; // [R06]
    end
  end

  logic sd_meta_q;
  logic sd_sync_q;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sd_meta_q <= 1'b0;
      sd_sync_q <= 1'b0;
    end else begin
      sd_meta_q <= sd_pin;
      sd_sync_q <= sd_meta_q;
    end
  end

  // Pin ignored means the receiver treats the signal as present
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      signal_detect <= 1'b1;
    end else begin
      signal_detect <= use_signal_detect_pin_q ? sd_sync_q : 1'b1; // [R06]
    end
  end

  // ----------------------------------------------------------------
  // Interrupt enables
  // ----------------------------------------------------------------
  logic [FPIR_NIRQ-1:0] irq_en_q;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irq_en_q <= FPIR_RST_IRQ_ENABLE; // [R07]
    end else if (reg_wr && sel_en) begin
      irq_en_q <= reg_wdata[FPIR_NIRQ-1:0]; // [R07]
    end
  end

  logic far_end_fault_irq_on;
  logic link_change_irq_on;
  logic remote_fault_irq_on;
  logic priority_fail_irq_on;
  logic next_page_rx_irq_on;
  logic base_page_rx_irq_on;

  assign far_end_fault_irq_on = irq_en_q[FPIR_IRQ_FAR_END_FAULT];
  assign link_change_irq_on = irq_en_q[FPIR_IRQ_LINK_CHANGE];
  assign remote_fault_irq_on = irq_en_q[FPIR_IRQ_REMOTE_FAULT];
  assign priority_fail_irq_on = irq_en_q[FPIR_IRQ_PRIORITY_FAIL];
  assign next_page_rx_irq_on = irq_en_q[FPIR_IRQ_NEXT_PAGE_RX];
  assign base_page_rx_irq_on = irq_en_q[FPIR_IRQ_BASE_PAGE_RX];

  // ----------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------
  // Levels are edge-detected so a FIFO sitting full raises one event
  logic tx_full_q;
  logic tx_empty_q;
  logic rx_full_q;
  logic rx_empty_q;
  logic link_up_q;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tx_full_q <= 1'b0;
      tx_empty_q <= 1'b0;
      rx_full_q <= 1'b0;
      rx_empty_q <= 1'b0;
      link_up_q <= 1'b0;
    end else begin
      tx_full_q <= tx_fifo_full;
      tx_empty_q <= tx_fifo_empty;
      rx_full_q <= rx_fifo_full;
      rx_empty_q <= rx_fifo_empty;
      link_up_q <= link_up;
    end
  end

  logic [FPIR_NIRQ-1:0] evt;

  always_comb begin
    evt = '0;
    evt[FPIR_IRQ_FAR_END_FAULT] = far_end_fault; // [R08]
    evt[FPIR_IRQ_TX_FIFO_FULL] = tx_fifo_full & ~tx_full_q; // [R09]
    evt[FPIR_IRQ_TX_FIFO_EMPTY] = tx_fifo_empty & ~tx_empty_q; // [R09]
    evt[FPIR_IRQ_RX_FIFO_FULL] = rx_fifo_full & ~rx_full_q; // [R10]
    evt[FPIR_IRQ_RX_FIFO_EMPTY] = rx_fifo_empty & ~rx_empty_q; // [R10]
    evt[FPIR_IRQ_LINK_CHANGE] = link_up ^ link_up_q; // [R11]
    evt[FPIR_IRQ_REMOTE_FAULT] = remote_fault_rx; // [R12]
    evt[FPIR_IRQ_PRIORITY_FAIL] = priority_fail; // [R13]
    evt[FPIR_IRQ_NEXT_PAGE_RX] = np_rx_valid; // [R14]
    evt[FPIR_IRQ_BASE_PAGE_RX] = bp_rx_valid; // [R14]
  end

  // ----------------------------------------------------------------
  // Pending flags
  // ----------------------------------------------------------------
  fpir_flag_if #(.N(FPIR_NIRQ)) flag_bus ();

  assign flag_bus.set = evt; // [R17]
  assign flag_bus.clr = reg_rd && sel_sts; // [R15]

  fpir_sticky #(.N(FPIR_NIRQ)) u_sticky (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .fl(flag_bus.store)
  );

  logic [FPIR_NIRQ-1:0] pending;

  assign pending = flag_bus.flags;

  logic far_end_fault_pending;
  logic link_change_pending;
  logic remote_fault_pending;
  logic priority_fail_pending;
  logic next_page_rx_pending;
  logic base_page_rx_pending;

  assign far_end_fault_pending = pending[FPIR_IRQ_FAR_END_FAULT];
  assign link_change_pending = pending[FPIR_IRQ_LINK_CHANGE];
  assign remote_fault_pending = pending[FPIR_IRQ_REMOTE_FAULT];
  assign priority_fail_pending = pending[FPIR_IRQ_PRIORITY_FAIL];
  assign next_page_rx_pending = pending[FPIR_IRQ_NEXT_PAGE_RX];
  assign base_page_rx_pending = pending[FPIR_IRQ_BASE_PAGE_RX];

  // Registered so the pin never glitches on flag updates
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flag_bus.flags & irq_en_q); // [R18]
    end
  end

  // ----------------------------------------------------------------
  // Test control: reverse loopback
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rev_loopback_en <= 1'b0; // [R16]
    end else if (reg_wr && sel_tst) begin
      rev_loopback_en <= reg_wdata[FPIR_TST_REV_LOOPBACK]; // [R16]
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [FPIR_DW-1:0] rd_mux;

  // Reserved and unmapped bits read as zero
  always_comb begin
    rd_mux = '0;
    if (sel_np) begin
      rd_mux = np_page_q; // [R01]
    end else if (sel_cfg) begin
      rd_mux[FPIR_CFG_USE_SD_PIN] = use_signal_detect_pin_q; // [R06]
    end else if (sel_en) begin
      rd_mux[FPIR_NIRQ-1:0] = irq_en_q; // [R07]
    end else if (sel_sts) begin
      rd_mux[FPIR_NIRQ-1:0] = pending; // [R15]
    end else if (sel_tst) begin
      rd_mux[FPIR_TST_REV_LOOPBACK] = rev_loopback_en; // [R16]
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  np_capture_a: assert property ( // [R01]
    np_rx_valid ##1 reg_rd && sel_np |=> reg_rdata == $past(np_rx_word, 2)
  ) else $error("next page read differs from captured word");

  np_fields_a: assert property ( // [R05]
    np_rx_valid |=> partner_message_code == $past(np_rx_word[FPIR_NP_CODE_MSB:0])
      && partner_toggle_bit == $past(np_rx_word[FPIR_NP_TOGGLE])
  ) else $error("next page fields not taken as received");

  sd_select_a: assert property ( // [R06]
    !use_signal_detect_pin_q && !$past(use_signal_detect_pin_q) |-> signal_detect
  ) else $error("signal detect follows pin while pin unused");

  en_write_a: assert property ( // [R07]
    reg_wr && sel_en |=> irq_en_q == $past(reg_wdata[FPIR_NIRQ-1:0])
  ) else $error("enable write not stored");

  fifo_edge_a: assert property ( // [R10]
    $rose(rx_fifo_full) ##1 !(reg_rd && sel_sts) [*2] |-> pending[FPIR_IRQ_RX_FIFO_FULL]
  ) else $error("rx fifo full did not set pending");

  link_change_a: assert property ( // [R11]
    link_up != link_up_q |=> link_change_pending
  ) else $error("link change did not set pending");

  read_clear_a: assert property ( // [R15]
    reg_rd && sel_sts && evt == '0 |=> pending == '0 ##0 reg_rdata[FPIR_NIRQ-1:0] == $past(pending)
  ) else $error("status read did not clear or report");

  set_wins_a: assert property ( // [R17]
    reg_rd && sel_sts && base_page_rx_pending && bp_rx_valid |=> base_page_rx_pending
  ) else $error("event lost during clearing read");

  irq_level_a: assert property ( // [R18]
    |(pending & irq_en_q) |=> irq
  ) else $error("interrupt not raised for enabled pending");

  irq_quiet_a: assert property ( // [R18]
    (pending & irq_en_q) == '0 |=> !irq
  ) else $error("interrupt raised with nothing enabled pending");

  loopback_a: assert property ( // [R16]
    reg_wr && sel_tst |=> rev_loopback_en == $past(reg_wdata[FPIR_TST_REV_LOOPBACK])
  ) else $error("loopback enable not stored");

endmodule : fpir_regs

// *** verif/tb_fpir.sv ***
/*
 * Self-checking testbench for the fiber next-page and interrupt register
 * bank. Drives the register port and the event inputs directly.
 * Assumes fpir_pkg and fpir_regs are compiled first; assertions live in
 * the design files.
 */
`timescale 1ns/1ps

module tb;
  import fpir_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk_sys;
  logic nrst;
  logic [FPIR_AW-1:0] reg_addr;
  logic [FPIR_DW-1:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [FPIR_DW-1:0] reg_rdata;
  logic [FPIR_DW-1:0] np_rx_word;
  logic [FPIR_NIRQ-1:0] ev;
  logic sd_pin;
  logic signal_detect;
  logic rev_loopback_en;
  logic irq;
  int failures;
  int checks_done;
  logic [FPIR_DW-1:0] np_words [2];

  fpir_regs fpir_regs_i (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .np_rx_valid(ev[1]),
    .np_rx_word(np_rx_word),
    .bp_rx_valid(ev[0]),
    .far_end_fault(ev[9]),
    .tx_fifo_full(ev[8]),
    .tx_fifo_empty(ev[7]),
    .rx_fifo_full(ev[6]),
    .rx_fifo_empty(ev[5]),
    .link_up(ev[4]),
    .remote_fault_rx(ev[3]),
    .priority_fail(ev[2]),
    .sd_pin(sd_pin),
    .signal_detect(signal_detect),
    .rev_loopback_en(rev_loopback_en),
    .irq(irq)
  );

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic end_of_test;
    $display("checks %0d, failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  task automatic wr_reg(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr_reg

  // Optional event bits ride along with the read strobe
  task automatic rd_reg(input logic [11:0] a, input logic [15:0] exp, input string what,
                        input logic [9:0] same_ev = 10'h000);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    ev <= same_ev;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    ev <= 10'h000;
    #1;
    chk(reg_rdata, exp, what);
  endtask : rd_reg

  task automatic pulse(input int i);
    @(posedge clk_sys);
    ev[i] <= 1'b1;
    @(posedge clk_sys);
    ev[i] <= 1'b0;
  endtask : pulse

  task automatic after_cycles(input int n, input logic got_sel, input logic exp, input string what);
    repeat (n) @(posedge clk_sys);
    #1;
    chk({15'h0000, got_sel ? irq : signal_detect}, {15'h0000, exp}, what);
  endtask : after_cycles

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  initial begin
    #(25ns * 5000);
    failures++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    np_rx_word = '0;
    ev = '0;
    sd_pin = 1'b0;
    failures = 0;
    checks_done = 0;
    np_words[0] = 16'hA9C5;
    np_words[1] = 16'h5234;
    repeat (8) @(posedge clk_sys);
    #1;
    chk({14'h0000, signal_detect, irq}, 16'h0002, "outputs in reset");
    nrst <= 1'b1;
    // Values after reset and unmapped space
    rd_reg(FPIR_OFS_PARTNER_NEXT_PAGE, 16'h0000, "next page reset");
    rd_reg(FPIR_OFS_FIBER_CONFIG_0, 16'h0000, "config reset");
    rd_reg(FPIR_OFS_FIBER_IRQ_ENABLE, 16'h03FF, "enable reset");
    rd_reg(FPIR_OFS_FIBER_IRQ_STATUS, 16'h0000, "status reset");
    rd_reg(FPIR_OFS_FIBER_TEST_CONTROL, 16'h0000, "test ctrl reset");
    rd_reg(12'hC0F, 16'h0000, "unmapped read");
    wr_reg(12'hC11, 16'hFFFF);
    rd_reg(FPIR_OFS_FIBER_CONFIG_0, 16'h0000, "unmapped write leak");
    // Next page capture, every field verbatim
    foreach (np_words[k]) begin
      @(posedge clk_sys);
      np_rx_word <= np_words[k];
      pulse(FPIR_IRQ_NEXT_PAGE_RX);
      rd_reg(FPIR_OFS_PARTNER_NEXT_PAGE, np_words[k], "next page word");
      rd_reg(FPIR_OFS_FIBER_IRQ_STATUS, 16'h0002, "next page status");
    end
    wr_reg(FPIR_OFS_PARTNER_NEXT_PAGE, 16'h0000);
    rd_reg(FPIR_OFS_PARTNER_NEXT_PAGE, np_words[1], "next page read-only");
    // Each source on its own bit, irq follows, read clears
    for (int i = 0; i < FPIR_NIRQ; i++) begin
      pulse(i);
      after_cycles(1, 1'b1, 1'b1, "irq raised");
      rd_reg(FPIR_OFS_FIBER_IRQ_STATUS, 16'h0001 << i, "source bit");
      after_cycles(1, 1'b1, 1'b0, "irq dropped");
      rd_reg(FPIR_OFS_FIBER_IRQ_STATUS, 16'h0000, "status cleared");
    end
    // Masked source latches but stays quiet until enabled
    wr_reg(FPIR_OFS_FIBER_IRQ_ENABLE, 16'hFFFF);
    rd_reg(FPIR_OFS_FIBER_IRQ_ENABLE, 16'h03FF, "enable width");
    wr_reg(FPIR_OFS_FIBER_IRQ_ENABLE, 16'h03F7);
    pulse(FPIR_IRQ_REMOTE_FAULT);
    after_cycles(3, 1'b1, 1'b0, "masked irq");
    wr_reg(FPIR_OFS_FIBER_IRQ_ENABLE, 16'h03FF);
    after_cycles(2, 1'b1, 1'b1, "unmasked irq");
    rd_reg(FPIR_OFS_FIBER_IRQ_STATUS, 16'h0008, "masked still pending");
    wr_reg(FPIR_OFS_FIBER_IRQ_ENABLE, 16'h0000);
    rd_reg(FPIR_OFS_FIBER_IRQ_ENABLE, 16'h0000, "enables off");
    wr_reg(FPIR_OFS_FIBER_IRQ_ENABLE, 16'h03FF);
    // Event in the clearing read cycle survives
    pulse(FPIR_IRQ_PRIORITY_FAIL);
    rd_reg(FPIR_OFS_FIBER_IRQ_STATUS, 16'h0004, "read with event", 10'h001);
    rd_reg(FPIR_OFS_FIBER_IRQ_STATUS, 16'h0001, "event kept");
    rd_reg(FPIR_OFS_FIBER_IRQ_STATUS, 16'h0000, "finally clear");
    // Signal detect pin selection
    wr_reg(FPIR_OFS_FIBER_CONFIG_0, 16'hFFFF);
    rd_reg(FPIR_OFS_FIBER_CONFIG_0, 16'h0200, "config bits");
    after_cycles(5, 1'b0, 1'b0, "pin low used");
    sd_pin <= 1'b1;
    after_cycles(5, 1'b0, 1'b1, "pin high used");
    sd_pin <= 1'b0;
    wr_reg(FPIR_OFS_FIBER_CONFIG_0, 16'h0000);
    after_cycles(5, 1'b0, 1'b1, "pin ignored");
    // Reverse loopback
    wr_reg(FPIR_OFS_FIBER_TEST_CONTROL, 16'h0020);
    rd_reg(FPIR_OFS_FIBER_TEST_CONTROL, 16'h0020, "loopback set");
    chk({15'h0000, rev_loopback_en}, 16'h0001, "loopback out on");
    wr_reg(FPIR_OFS_FIBER_TEST_CONTROL, 16'h0000);
    rd_reg(FPIR_OFS_FIBER_TEST_CONTROL, 16'h0000, "loopback clear");
    chk({15'h0000, rev_loopback_en}, 16'h0000, "loopback out off");
    end_of_test();
  end
endmodule : tb
